// ==== common/smt_pkg.sv ====
// shared constants and carrier types for the sixteen bit multimode timer
package smt_pkg;

  // ********************************
  // widths, counts and reset values
  // ********************************
  localparam int CNT_W = 16;
  localparam int DIV_W = 11;
  localparam int TAP_FAST = 3;      // high_clock / 8
  localparam int TAP_MID = 7;       // high_clock / 128
  localparam int TAP_SLOW = 11;     // high_clock / 2048
  localparam int FILT_REJECT = 7;   // pulses this long or shorter are noise
  localparam logic [3:0] FILT_ACCEPT = 4'(FILT_REJECT + 1);
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic PULSE_RST = 1'b0;

  // ********************************
  // control register field codes
  // ********************************
  localparam logic [2:0] MODE_TIMER = 3'h0;
  localparam logic [2:0] MODE_TRIG = 3'h1;
  localparam logic [2:0] MODE_EVENT = 3'h2;
  localparam logic [2:0] MODE_WINDOW = 3'h3;
  localparam logic [2:0] MODE_PWIDTH = 3'h4;
  localparam logic [2:0] MODE_PULSE = 3'h5;
  localparam logic [1:0] START_STOP = 2'h0;
  localparam logic [1:0] START_SOFT = 2'h1;
  localparam logic [1:0] START_EXT = 2'h2;
  localparam logic [1:0] CLK_DIV8 = 2'h0;
  localparam logic [1:0] CLK_DIV128 = 2'h1;

  // control word: mode in bits 10:8, bit 6 capture, 5:4 start, 3:2 clock
  typedef struct packed {
    logic [2:0] mode_select_field;
    logic rsvd7;
    logic cap_bit;                  // soft_capture_bit or dual_edge_capture_bit
    logic [1:0] start_control_field;
    logic [1:0] clock_select_field;
    logic [1:0] rsvd;
  } smt_ctrl_t;
  localparam smt_ctrl_t CTRL_RST = smt_ctrl_t'(11'h000);

  // data registers kept through reset
  typedef struct packed {
    logic [CNT_W-1:0] compare_a_register;
    logic [CNT_W-1:0] capture_b_register;
  } smt_data_t;

  // all reset state of the timer
  typedef struct packed {
    smt_ctrl_t ctrl;
    logic [CNT_W-1:0] count;
    logic run;
    logic pulse_toggle_flop;
    logic irq;
    logic [DIV_W-1:0] div;
    logic [2:0] ldiv;
    logic [2:0] tin_s;
    logic [2:0] lck_s;
    logic lck_lvl;
    logic tin_f;
    logic [3:0] flt_cnt;
  } smt_state_t;

endpackage

// ==== verilog/smt_timer.sv ====
// sixteen bit multimode timer/counter with capture and pulse output
`timescale 1ns/1ns

// Notes on behaviour
// [RULE1] six modes: timer, triggered timer, event, window, pulse width, pulse out
// [RULE2] compare and capture registers are 16 bits and survive reset
// [RULE3] timer mode counts internal clock; match raises interrupt, clears, continues
// [RULE4] writing capture bit copies count to capture register, then bit self-clears
// [RULE5] clock select picks high_clock /8, /128, /2048 or low_clock/8
// [RULE6] triggered mode starts on chosen edge; match interrupts, clears and halts
// [RULE7] normal modes reject pulses of 7 cycles or less; slow modes unfiltered
// [RULE8] event mode counts selected input edges; match interrupts and clears
// [RULE9] source keeps event rate at or below clock/16
// [RULE10] software capture also works in event and window modes
// [RULE11] window mode counts internal clock while input at selected level
// [RULE12] window signal changes much slower than count clock
// [RULE13] pulse width: start on trigger edge, capture and interrupt on opposite
// [RULE14] bit 6 picks single edge (clear) or double edge (keep counting)
// [RULE15] software reads first capture before the next edge overwrites it
// [RULE16] start field picks software start or external edge start
// [RULE17] pulse mode: capture match toggles flop; compare match toggles, clears
// [RULE18] toggle flop drives pulse pin, resets to 0, software can preset it
// [RULE19] capture register writes ignored outside pulse output mode
// [RULE20] software sets port latch and direction before pulse output
// [RULE21] prescaler never cleared so first tick may come early
// [RULE22] counter is 16 bits; match is full 16 bit equality
module smt_timer
  import smt_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // control register write
  input wire logic i_ctrl_we,
  input wire smt_ctrl_t i_ctrl_wdata,
  // data register writes
  input wire logic i_cmpa_we,
  input wire logic i_capb_we,
  input wire logic [CNT_W-1:0] i_wdata,
  // pulse flop preset
  input wire logic i_ff_we,
  input wire logic i_ff_wdata,
  // system configuration
  input wire logic i_slow_mode,
  input wire logic i_divider_clock_source_bit,
  input wire logic i_edge_polarity_select,
  // pins and low clock
  input wire logic i_timer_input_pin,
  input wire logic i_low_clock,
  // outputs
  output logic o_timer1_interrupt,
  output logic o_pulse_output_pin,
  output smt_ctrl_t o_ctrl,
  output smt_data_t o_data,
  output logic [CNT_W-1:0] o_count,
  output logic o_running
);

  // ********************************
  // state
  // ********************************
  smt_state_t q;
  smt_state_t d;
  smt_data_t dq;
  smt_data_t dd;
  logic lck_edge;
  logic tick;
  logic rise;
  logic fall;
  logic trig_edge;
  logic opp_edge;
  logic match_a;
  logic match_b;
  logic level_on;

  // next state of everything
  always_comb begin
    d = q;
    dd = dq;
    d.irq = 1'b0;
    // three stage synchronisers
    d.tin_s = {q.tin_s[1:0], i_timer_input_pin};
    d.lck_s = {q.lck_s[1:0], i_low_clock};
    // free running prescaler, never cleared [RULE21]
    d.div = q.div + 11'h001;
    // low clock rising edges, divided by 8
    lck_edge = (q.lck_s[1] == q.lck_s[2]) && q.lck_s[2] && !q.lck_lvl;
    if (q.lck_s[1] == q.lck_s[2]) begin
      d.lck_lvl = q.lck_s[2];
    end
    if (lck_edge) begin
      d.ldiv = q.ldiv + 3'h1;
    end
    // count clock selection [RULE5]
    if (i_slow_mode) begin
      tick = lck_edge && (&q.ldiv);
    end else if (q.ctrl.clock_select_field == CLK_DIV8) begin
      tick = &q.div[TAP_FAST-1:0];
    end else if (q.ctrl.clock_select_field == CLK_DIV128) begin
      tick = &q.div[TAP_MID-1:0];
    end else if (i_divider_clock_source_bit) begin
      tick = lck_edge && (&q.ldiv);
    end else begin
      tick = &q.div[TAP_SLOW-1:0];
    end
    // input noise filter, off in slow mode [RULE7]
    if (q.tin_s[1] != q.tin_s[2] || q.tin_s[2] == q.tin_f) begin
      d.flt_cnt = 4'h0;
    end else if (i_slow_mode || q.flt_cnt == FILT_ACCEPT - 4'h1) begin
      d.tin_f = q.tin_s[2];
      d.flt_cnt = 4'h0;
    end else begin
      d.flt_cnt = q.flt_cnt + 4'h1;
    end
    rise = d.tin_f && !q.tin_f;
    fall = !d.tin_f && q.tin_f;
    trig_edge = i_edge_polarity_select ? fall : rise;
    opp_edge = i_edge_polarity_select ? rise : fall;
    level_on = q.tin_f ^ i_edge_polarity_select;
    // full width equality compare [RULE22]
    match_a = q.count == dq.compare_a_register;
    match_b = q.count == dq.capture_b_register;
    // external start on the selected edge [RULE16]
    if (q.ctrl.start_control_field == START_EXT && !q.run && trig_edge
        && q.ctrl.mode_select_field != MODE_PWIDTH) begin
      d.run = 1'b1;
    end
    // per mode counting [RULE1]
    unique case (q.ctrl.mode_select_field)
      MODE_TIMER, MODE_WINDOW: begin
        // window counts only while input at active level [RULE11]
        if (q.run && tick && (level_on
            || q.ctrl.mode_select_field == MODE_TIMER)) begin
          if (match_a) begin
            d.count = CNT_RST; // [RULE3]
            d.irq = 1'b1;
          end else begin
            d.count = q.count + 16'h0001;
          end
        end
      end
      MODE_TRIG: begin
        if (q.run && tick) begin
          if (match_a) begin
            d.count = CNT_RST; // halt until the next edge [RULE6]
            d.run = 1'b0;
            d.irq = 1'b1;
          end else begin
            d.count = q.count + 16'h0001;
          end
        end
      end
      MODE_EVENT: begin
        if (q.run && trig_edge) begin
          if (match_a) begin
            d.count = CNT_RST; // [RULE8]
            d.irq = 1'b1;
          end else begin
            d.count = q.count + 16'h0001;
          end
        end
      end
      MODE_PWIDTH: begin
        if (!q.run) begin
          // armed: wait for the trigger edge [RULE13]
          if (trig_edge && q.ctrl.start_control_field != START_STOP) begin
            d.run = 1'b1;
            d.count = CNT_RST;
          end
        end else if (opp_edge) begin
          dd.capture_b_register = q.count; // [RULE13]
          d.irq = 1'b1;
          if (!q.ctrl.cap_bit) begin
            d.count = CNT_RST; // single edge clears and rearms [RULE14]
            d.run = 1'b0;
          end
        end else if (trig_edge && q.ctrl.cap_bit) begin
          dd.capture_b_register = q.count; // period capture [RULE14]
          d.irq = 1'b1;
          d.count = CNT_RST;
        end else if (tick) begin
          d.count = q.count + 16'h0001;
        end
      end
      MODE_PULSE: begin
        if (q.run && tick) begin
          if (match_a) begin
            d.pulse_toggle_flop = !q.pulse_toggle_flop; // [RULE17]
            d.count = CNT_RST;
            d.irq = 1'b1;
          end else begin
            if (match_b) begin
              d.pulse_toggle_flop = !q.pulse_toggle_flop; // [RULE17]
            end
            d.count = q.count + 16'h0001;
          end
        end
      end
      default: begin
        d.run = 1'b0;
      end
    endcase
    // software capture leaves counting alone [RULE4] [RULE10]
    if (q.ctrl.cap_bit && (q.ctrl.mode_select_field == MODE_TIMER
        || q.ctrl.mode_select_field == MODE_EVENT
        || q.ctrl.mode_select_field == MODE_WINDOW)) begin
      dd.capture_b_register = q.count;
      d.ctrl.cap_bit = 1'b0;
    end
    // software writes
    if (i_ctrl_we) begin
      d.ctrl = i_ctrl_wdata;
      if (i_ctrl_wdata.start_control_field == START_SOFT) begin
        d.run = 1'b1; // [RULE16]
      end else if (i_ctrl_wdata.start_control_field == START_STOP) begin
        d.run = 1'b0;
        d.count = CNT_RST;
      end else if (q.ctrl.start_control_field != START_EXT) begin
        d.run = 1'b0; // wait for the external edge
        d.count = CNT_RST;
      end
    end
    if (i_cmpa_we) begin
      dd.compare_a_register = i_wdata;
    end
    if (i_capb_we && q.ctrl.mode_select_field == MODE_PULSE) begin
      dd.capture_b_register = i_wdata; // [RULE19]
    end
    if (i_ff_we) begin
      d.pulse_toggle_flop = i_ff_wdata; // preset [RULE18]
    end
  end

  // reset state registers
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
      q.ctrl <= CTRL_RST;
      q.count <= CNT_RST;
      q.pulse_toggle_flop <= PULSE_RST; // [RULE18]
    end else begin
      q <= d;
    end
  end

  // data registers with no reset [RULE2]
  always_ff @(posedge i_clock) begin
    dq <= dd;
  end

  // outputs straight from flops
  assign o_timer1_interrupt = q.irq;
  assign o_pulse_output_pin = q.pulse_toggle_flop;
  assign o_ctrl = q.ctrl;
  assign o_data = dq;
  assign o_count = q.count;
  assign o_running = q.run;

  // ********************************
  // assertions
  // ********************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  property p_timer_match;
    q.ctrl.mode_select_field == MODE_TIMER && q.run && tick && match_a
      && !i_ctrl_we |=> q.count == 16'h0000 && q.irq && q.run;
  endproperty
  a_timer_match: assert property (p_timer_match) // [RULE3]
    else $error("timer match did not clear and interrupt");

  property p_soft_cap;
    q.ctrl.cap_bit && q.ctrl.mode_select_field == MODE_EVENT && !i_ctrl_we
      |=> dq.capture_b_register == $past(q.count) && !q.ctrl.cap_bit;
  endproperty
  a_soft_cap: assert property (p_soft_cap) // [RULE10]
    else $error("software capture failed");

  property p_trig_halt;
    q.ctrl.mode_select_field == MODE_TRIG && q.run && tick && match_a
      && !i_ctrl_we |=> !q.run ##1 !q.irq;
  endproperty
  a_trig_halt: assert property (p_trig_halt) // [RULE6]
    else $error("triggered timer did not halt");

  property p_event_step;
    q.ctrl.mode_select_field == MODE_EVENT && q.run && trig_edge && !match_a
      && !i_ctrl_we |=> q.count == $past(q.count) + 16'h0001;
  endproperty
  a_event_step: assert property (p_event_step) // [RULE8]
    else $error("event edge not counted");

  property p_capb_block;
    q.ctrl.mode_select_field == MODE_TRIG && !i_ctrl_we
      |=> $stable(dq.capture_b_register);
  endproperty
  a_capb_block: assert property (p_capb_block) // [RULE19]
    else $error("capture register changed outside pulse mode");

  property p_pulse_toggle;
    q.ctrl.mode_select_field == MODE_PULSE && q.run && tick && match_b
      && !match_a && !i_ff_we |=> q.pulse_toggle_flop != $past(q.pulse_toggle_flop);
  endproperty
  a_pulse_toggle: assert property (p_pulse_toggle) // [RULE17]
    else $error("pulse flop did not toggle");

  property p_filter;
    !i_slow_mode && $changed(q.tin_f)
      |-> $past(q.flt_cnt) == FILT_ACCEPT - 4'h1;
  endproperty
  a_filter: assert property (p_filter) // [RULE7]
    else $error("input accepted before filter time");

  property p_pw_capture;
    q.ctrl.mode_select_field == MODE_PWIDTH && q.run && opp_edge
      && !q.ctrl.cap_bit && !i_ctrl_we
      |=> q.irq && !q.run && dq.capture_b_register == $past(q.count);
  endproperty
  a_pw_capture: assert property (p_pw_capture) // [RULE13]
    else $error("pulse width capture missing");

  property p_ff_preset;
    i_ff_we |=> q.pulse_toggle_flop == $past(i_ff_wdata);
  endproperty
  a_ff_preset: assert property (p_ff_preset) // [RULE18]
    else $error("pulse flop preset lost");

  c_timer_irq: cover property (q.ctrl.mode_select_field == MODE_TIMER
    && q.irq);
  c_pw_dual: cover property (q.ctrl.mode_select_field == MODE_PWIDTH
    && q.ctrl.cap_bit && q.irq);
  c_pulse_out: cover property (q.ctrl.mode_select_field == MODE_PULSE
    && $rose(q.pulse_toggle_flop));
  c_window: cover property (q.ctrl.mode_select_field == MODE_WINDOW
    && q.irq);

endmodule

// ==== tb/smt_src_model.sv ====
// external pulse source on the timer input pin, plus a free low clock
`timescale 1ns/1ns

module smt_src_model (
  // clock
  input wire logic i_clock,
  // pin side
  output logic o_pin,
  output logic o_low_clock
);
  initial o_pin = 1'b0;
  initial o_low_clock = 1'b0;

  // low clock runs free, far slower than the main clock
  always #150 o_low_clock = ~o_low_clock;

  // one pulse of w cycles then gap idle cycles; w >= 24 for real edges,
  // w under 8 models a glitch that the filter has to drop
  // and edges 16 or more cycles apart, and window levels slow
  task automatic pulse(input int w, input int gap);
    @(negedge i_clock);
    o_pin = 1'b1;
    repeat (w) @(negedge i_clock);
    o_pin = 1'b0;
    repeat (gap) @(negedge i_clock);
  endtask
endmodule

// ==== tb/sixteen_bit_multimode_timer_tb_top.sv ====
// self-checking bench for the sixteen bit multimode timer
`timescale 1ns/1ns

module sixteen_bit_multimode_timer_tb_top;
  import smt_pkg::*;
  logic i_clock = 1'b0;
  logic i_arst_n = 1'b0;
  logic ctrl_we = 1'b0, cmpa_we = 1'b0, capb_we = 1'b0;
  logic ff_we = 1'b0, ff_wd = 1'b0, pol = 1'b0;
  logic slow = 1'b0, dcs = 1'b0;
  smt_ctrl_t ctrl_wd = CTRL_RST;
  logic [15:0] wdata = 16'h0000;
  logic pin, lck, irq, ppin, run;
  smt_ctrl_t ctrl;
  smt_data_t data;
  logic [15:0] cnt, b0;
  int error_cnt = 0, samples_checked = 0, cyc, tog;
  int taps [3] = '{TAP_FAST, TAP_MID, TAP_SLOW};

  always #5 i_clock = ~i_clock;

  smt_src_model u_src (.i_clock(i_clock), .o_pin(pin), .o_low_clock(lck));

  smt_timer uut (
    .i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_ctrl_we(ctrl_we), .i_ctrl_wdata(ctrl_wd),
    .i_cmpa_we(cmpa_we), .i_capb_we(capb_we), .i_wdata(wdata),
    .i_ff_we(ff_we), .i_ff_wdata(ff_wd),
    .i_slow_mode(slow), .i_divider_clock_source_bit(dcs),
    .i_edge_polarity_select(pol),
    .i_timer_input_pin(pin), .i_low_clock(lck),
    .o_timer1_interrupt(irq), .o_pulse_output_pin(ppin),
    .o_ctrl(ctrl), .o_data(data), .o_count(cnt), .o_running(run)
  );

  // ********************************
  // compare, verdict and access tasks
  // ********************************
  task automatic check(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wr_ctrl(input logic [2:0] m, input logic cap,
                         input logic [1:0] st, input logic [1:0] ck);
    @(negedge i_clock);
    ctrl_wd = '{m, 1'b0, cap, st, ck, 2'h0};
    ctrl_we = 1'b1;
    @(negedge i_clock);
    ctrl_we = 1'b0;
  endtask

  task automatic wr_reg(input logic sel_b, input logic [15:0] v);
    @(negedge i_clock);
    wdata = v;
    cmpa_we = ~sel_b;
    capb_we = sel_b;
    @(negedge i_clock);
    cmpa_we = 1'b0;
    capb_we = 1'b0;
  endtask

  // waits for the interrupt, counting cycles and pulse pin toggles
  task automatic wait_irq(input int lim);
    logic last;
    last = ppin;
    cyc = 0;
    tog = 0;
    do begin
      @(negedge i_clock);
      cyc++;
      if (ppin !== last) tog++;
      last = ppin;
      if (cyc > lim) begin
        error_cnt++;
        $display("[ERR] interrupt expected 1 seen 0");
        conclude();
      end
    end while (irq !== 1'b1);
  endtask

  // ********************************
  // test sequence
  // ********************************
  initial begin
    repeat (12) @(negedge i_clock);
    i_arst_n = 1'b1;
    check("ctrl", 16'(ctrl), 16'(CTRL_RST));
    check("count", cnt, 16'h0000);
    check("pin", 16'(ppin), 16'h0000);
    check("run", 16'(run), 16'h0000);
    $display("test reset done");
    // timer mode at each clock tap
    wr_reg(1'b0, 16'h0001);
    for (int k = 0; k < 3; k++) begin
      wr_ctrl(MODE_TIMER, 1'b0, START_SOFT, 2'(k));
      wait_irq(9000);
      wait_irq(9000);
      check("period", 16'(cyc), 16'(2 << taps[k]));
      check("count", cnt, 16'h0000);
    end
    // low clock taps: two ticks of 8 low clock periods of 30 cycles
    @(negedge i_clock) dcs = 1'b1;
    wr_ctrl(MODE_TIMER, 1'b0, START_SOFT, 2'h2);
    wait_irq(1200);
    wait_irq(1200);
    check("low period", 16'(cyc), 16'h01E0);
    @(negedge i_clock) dcs = 1'b0;
    slow = 1'b1;
    wr_ctrl(MODE_TIMER, 1'b0, START_SOFT, CLK_DIV8);
    wait_irq(1200);
    wait_irq(1200);
    check("slow period", 16'(cyc), 16'h01E0);
    @(negedge i_clock) slow = 1'b0;
    $display("test timer done");
    // software capture of a stopped count, write lock, then pulse output
    // the pulse pin is watched directly; port latch setup is outside
    wr_ctrl(MODE_TIMER, 1'b1, START_STOP, CLK_DIV8);
    wr_reg(1'b1, 16'h1234);
    check("capb", data.capture_b_register, 16'h0000);
    check("cap bit", 16'(ctrl.cap_bit), 16'h0000);
    wr_ctrl(MODE_PULSE, 1'b0, START_STOP, CLK_DIV8);
    wr_reg(1'b1, 16'h0003);
    check("capb", data.capture_b_register, 16'h0003);
    wr_reg(1'b0, 16'h0007);
    @(negedge i_clock);
    ff_we = 1'b1;
    ff_wd = 1'b1;
    @(negedge i_clock);
    ff_we = 1'b0;
    check("pin", 16'(ppin), 16'h0001);
    wr_ctrl(MODE_PULSE, 1'b0, START_SOFT, CLK_DIV8);
    wait_irq(200);
    wait_irq(200);
    check("toggles", 16'(tog), 16'h0002);
    check("pin", 16'(ppin), 16'h0001);
    check("period", 16'(cyc), 16'h0040);
    $display("test pulse done");
    // event counter with a glitch and software capture
    wr_reg(1'b0, 16'hFFFF);
    wr_ctrl(MODE_EVENT, 1'b0, START_STOP, CLK_DIV8);
    wr_ctrl(MODE_EVENT, 1'b0, START_SOFT, CLK_DIV8);
    repeat (3) u_src.pulse(30, 30);
    u_src.pulse(5, 20);
    wr_ctrl(MODE_EVENT, 1'b1, START_SOFT, CLK_DIV8);
    @(negedge i_clock);
    check("capb", data.capture_b_register, 16'h0003);
    check("cap bit", 16'(ctrl.cap_bit), 16'h0000);
    check("count", cnt, 16'h0003);
    wr_reg(1'b0, 16'h0003);
    fork
      u_src.pulse(30, 30);
      wait_irq(100);
    join
    check("count", cnt, 16'h0000);
    // inverted polarity counts falling edges only
    wr_ctrl(MODE_EVENT, 1'b0, START_STOP, CLK_DIV8);
    @(negedge i_clock) pol = 1'b1;
    wr_ctrl(MODE_EVENT, 1'b0, START_SOFT, CLK_DIV8);
    repeat (2) u_src.pulse(30, 30);
    check("fall count", cnt, 16'h0002);
    @(negedge i_clock) pol = 1'b0;
    $display("test event done");
    // window mode
    wr_reg(1'b0, 16'hFFFF);
    wr_ctrl(MODE_WINDOW, 1'b0, START_STOP, CLK_DIV8);
    wr_ctrl(MODE_WINDOW, 1'b0, START_SOFT, CLK_DIV8);
    u_src.pulse(160, 40);
    check("window", 16'(cnt >= 18 && cnt <= 22), 16'h0001);
    wr_ctrl(MODE_WINDOW, 1'b1, START_SOFT, CLK_DIV8);
    @(negedge i_clock);
    check("capb", data.capture_b_register, cnt);
    $display("test window done");
    // triggered timer halts on match and restarts on the edge
    wr_reg(1'b0, 16'h0002);
    wr_ctrl(MODE_TRIG, 1'b0, START_STOP, CLK_DIV8);
    wr_ctrl(MODE_TRIG, 1'b0, START_EXT, CLK_DIV8);
    repeat (2) begin
      fork
        u_src.pulse(30, 60);
        wait_irq(200);
      join
      check("run", 16'(run), 16'h0000);
      check("count", cnt, 16'h0000);
    end
    $display("test trigger done");
    // pulse width, single then double edge
    wr_reg(1'b0, 16'hFFFF);
    wr_ctrl(MODE_PWIDTH, 1'b0, START_STOP, CLK_DIV8);
    wr_ctrl(MODE_PWIDTH, 1'b0, START_EXT, CLK_DIV8);
    fork
      u_src.pulse(200, 40);
      wait_irq(300);
    join
    b0 = data.capture_b_register;
    check("width", 16'(b0 >= 24 && b0 <= 26), 16'h0001);
    check("count", cnt, 16'h0000);
    wr_ctrl(MODE_PWIDTH, 1'b1, START_STOP, CLK_DIV8);
    wr_ctrl(MODE_PWIDTH, 1'b1, START_EXT, CLK_DIV8);
    fork
      begin
        u_src.pulse(100, 100);
        u_src.pulse(40, 40);
      end
      begin
        wait_irq(300);
        b0 = data.capture_b_register;
        check("high", 16'(b0 >= 11 && b0 <= 13), 16'h0001);
        wait_irq(300);
        b0 = data.capture_b_register;
      end
    join
    check("period", 16'(b0 >= 24 && b0 <= 26), 16'h0001);
    $display("test width done");
    // data registers survive a mid-run reset
    b0 = data.capture_b_register;
    @(negedge i_clock) i_arst_n = 1'b0;
    repeat (3) @(negedge i_clock);
    i_arst_n = 1'b1;
    check("capb", data.capture_b_register, b0);
    check("cmpa", data.compare_a_register, 16'hFFFF);
    check("pin", 16'(ppin), 16'h0000);
    $display("test retention done");
    conclude();
  end
endmodule
